// File: hdl/ecl_loader.sv
// Overview of operation
// - port 4 word 68h bit0 to C0h bit24
// - port 4 bit1 to D0h bit28
// - port 4 bit2 to 40h bit21
// - port 4 bit3 to 144h bit4
// - port 4 bits 6:4 to CCh 26:24
// - port 4 bits 15:9 to 154h 7:1
// - port 3 bits 15:9 to 154h 7:1
// - port 5 word 6Ah, port 4 layout
// - port 5 bit3 to 144h bit4
// - port 0 word 70h into 214h fields
// - port 0 bit15 to 218h bit0
// - port 1 word 72h, same power layout
// - port 2 word 74h, same power layout
//
// Implementation choices: the register addresses and the APB slave port.
module ecl_loader (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ecl_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic mem_rd_req,
    output logic [ecl_pkg::MEM_AW-1:0] mem_addr,
    input wire logic mem_rd_ack,
    input wire logic [ecl_pkg::WORD_W-1:0] mem_rd_data,
    output logic load_busy,
    output logic load_done
);
    import ecl_pkg::*;

    ecl_regs_t r;
    ecl_regs_t r_nxt;
    logic [NPORT-1:0][NREG-1:0][31:0] port_dw;
    logic setup;
    logic access;
    logic hit;
    logic [2:0] win_port;
    logic [2:0] win_reg;
    logic reload_wr;

    genvar gp;
    generate
        for (gp = 0; gp < NPORT; gp++) begin : g_port
            ecl_word_map u_map (
                .kind(PORT_KIND[gp]),
                .loaded(r.loaded),
                .word(r.words[gp]),
                .dw(port_dw[gp])
            );
        end
    endgenerate

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign win_port = paddr[7:5];
    assign win_reg = paddr[4:2];
    assign hit = (paddr == CTRL_OFS) || (paddr == STAT_OFS) ||
        (paddr[11:8] == PORT_PAGE && win_port < 3'(NPORT) && paddr[1:0] == 2'h0);
    // reload while busy is dropped: the running pass already refreshes everything
    assign reload_wr = access && pwrite && paddr == CTRL_OFS && pwdata[CTRL_RELOAD];

    always_comb begin
        r_nxt = r;
        // read data is captured in the setup cycle so the access phase needs no wait
        if (setup) begin
            r_nxt.pslverr = !hit;
            r_nxt.prdata = 32'h0000_0000;
            if (paddr == STAT_OFS) begin
                r_nxt.prdata[STAT_BUSY] = r.busy;
                r_nxt.prdata[STAT_DONE] = r.loaded;
            end else if (hit && paddr[11:8] == PORT_PAGE) begin
                r_nxt.prdata = port_dw[win_port][win_reg];
            end
        end
        case (r.st)
            ST_IDLE: begin
                if (!r.started || (reload_wr && !r.busy)) begin
                    r_nxt.started = 1'b1;
                    r_nxt.busy = 1'b1;
                    r_nxt.idx = 3'h0;
                    r_nxt.mem_req = 1'b1;
                    r_nxt.mem_addr = WORD_ADDR[0];
                    r_nxt.st = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (mem_rd_ack) begin
                    r_nxt.stage[r.idx] = mem_rd_data;
                    r_nxt.mem_req = 1'b0;
                    r_nxt.st = ST_STEP;
                end
            end
            ST_STEP: begin
                if (r.idx == 3'(NPORT - 1)) begin
                    r_nxt.st = ST_COMMIT;
                end else begin
                    r_nxt.idx = r.idx + 3'h1;
                    r_nxt.mem_req = 1'b1;
                    r_nxt.mem_addr = WORD_ADDR[r.idx + 3'h1];
                    r_nxt.st = ST_FETCH;
                end
            end
            ST_COMMIT: begin
                // all ports switch in one edge; no half-loaded set is ever visible
                r_nxt.words = r.stage;
                r_nxt.loaded = 1'b1;
                r_nxt.busy = 1'b0;
                r_nxt.st = ST_IDLE;
            end
            default: begin
                r_nxt.st = ST_IDLE;
                r_nxt.mem_req = 1'b0;
                r_nxt.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    assign prdata = r.prdata;
    assign pslverr = r.pslverr;
    assign pready = 1'b1;
    assign mem_rd_req = r.mem_req;
    assign mem_addr = r.mem_addr;
    assign load_busy = r.busy;
    assign load_done = r.loaded;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    property p_p4_slot;
        r.loaded |-> port_dw[4][RI_SLOT] == (r.words[4][0] ? 32'h0100_0000 : 32'h0000_0000);
    endproperty
    a_p4_slot: assert property (p_p4_slot) else $error("port 4 slot bit wrong");

    property p_p4_sclk;
        r.loaded |-> port_dw[4][RI_SCLK] == (r.words[4][1] ? 32'h1000_0000 : 32'h0000_0000);
    endproperty
    a_p4_sclk: assert property (p_p4_sclk) else $error("port 4 slot clock bit wrong");

    property p_p4_dsi;
        r.loaded |-> port_dw[4][RI_DSI] == (r.words[4][2] ? 32'h0020_0000 : 32'h0000_0000);
    endproperty
    a_p4_dsi: assert property (p_p4_dsi) else $error("port 4 init bit wrong");

    property p_p4_lp_group;
        r.loaded |-> port_dw[4][RI_LP_GROUP] == (r.words[4][3] ? 32'h0000_0010 : 32'h0000_0000);
    endproperty
    a_p4_lp_group: assert property (p_p4_lp_group) else $error("port 4 low priority group bit wrong");

    property p_p4_pnum;
        r.loaded |-> port_dw[4][RI_PNUM] == {5'h00, r.words[4][6:4], 24'h00_0000};
    endproperty
    a_p4_pnum: assert property (p_p4_pnum) else $error("port 4 port number wrong");

    property p_p4_tcmap;
        r.loaded |-> port_dw[4][RI_TCMAP] == {24'h00_0000, r.words[4][15:9], 1'h0};
    endproperty
    a_p4_tcmap: assert property (p_p4_tcmap) else $error("port 4 tc map wrong");

    property p_p3_only_map;
        r.loaded |-> port_dw[3][RI_TCMAP] == {24'h00_0000, r.words[3][15:9], 1'h0} &&
            port_dw[3][RI_SLOT] == 32'h0000_0000 && port_dw[3][RI_PBDATA] == 32'h0000_0000;
    endproperty
    a_p3_only_map: assert property (p_p3_only_map) else $error("port 3 map or stray bits wrong");

    property p_p5_layout;
        r.loaded |-> port_dw[5][RI_PNUM] == {5'h00, r.words[5][6:4], 24'h00_0000} &&
            port_dw[5][RI_SLOT][24] == r.words[5][0] && port_dw[5][RI_DSI][21] == r.words[5][2];
    endproperty
    a_p5_layout: assert property (p_p5_layout) else $error("port 5 layout wrong");

    property p_p5_lp_group;
        r.loaded |-> port_dw[5][RI_LP_GROUP] == (r.words[5][3] ? 32'h0000_0010 : 32'h0000_0000);
    endproperty
    a_p5_lp_group: assert property (p_p5_lp_group) else $error("port 5 low priority group bit wrong");

    property p_p0_pbdata;
        r.loaded |-> port_dw[0][RI_PBDATA] == {17'h0_0000, r.words[0][11:10], 3'h0, r.words[0][9:0]};
    endproperty
    a_p0_pbdata: assert property (p_p0_pbdata) else $error("port 0 power data wrong");

    property p_p0_pbcap;
        r.loaded |-> port_dw[0][RI_PBCAP] == {31'h0000_0000, r.words[0][15]};
    endproperty
    a_p0_pbcap: assert property (p_p0_pbcap) else $error("port 0 system allocated wrong");

    property p_p1_power;
        r.loaded |-> port_dw[1][RI_PBDATA] == {17'h0_0000, r.words[1][11:10], 3'h0, r.words[1][9:0]} &&
            port_dw[1][RI_PBCAP] == {31'h0000_0000, r.words[1][15]};
    endproperty
    a_p1_power: assert property (p_p1_power) else $error("port 1 power layout wrong");

    property p_p2_power;
        r.loaded |-> port_dw[2][RI_PBDATA] == {17'h0_0000, r.words[2][11:10], 3'h0, r.words[2][9:0]};
    endproperty
    a_p2_power: assert property (p_p2_power) else $error("port 2 power layout wrong");

    property p_hold_defaults;
        !r.loaded |-> port_dw == '0;
    endproperty
    a_hold_defaults: assert property (p_hold_defaults) else $error("fields shown before load");

    property p_commit;
        r.st == ST_COMMIT |=> r.loaded && !r.busy && r.words == $past(r.stage);
    endproperty
    a_commit: assert property (p_commit) else $error("commit did not publish staged words");

    property p_stable_busy;
        r.busy && r.st != ST_COMMIT |=> $stable(r.words);
    endproperty
    a_stable_busy: assert property (p_stable_busy) else $error("fields changed mid load");

    property p_no_stray;
        port_dw[0][RI_SLOT] == 32'h0000_0000 && port_dw[4][RI_PBDATA] == 32'h0000_0000 &&
            (port_dw[2][RI_PBDATA] & 32'hFFFF_9C00) == 32'h0000_0000;
    endproperty
    a_no_stray: assert property (p_no_stray) else $error("bit outside map changed");

    property p_req_hold;
        r.mem_req && !mem_rd_ack |=> r.mem_req && $stable(r.mem_addr);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("memory request dropped early");

    property p_p5_sclk;
        r.loaded |-> port_dw[5][RI_SCLK] == (r.words[5][1] ? 32'h1000_0000 : 32'h0000_0000);
    endproperty
    a_p5_sclk: assert property (p_p5_sclk) else $error("port 5 slot clock bit wrong");

    property p_p5_tcmap;
        r.loaded |-> port_dw[5][RI_TCMAP] == {24'h00_0000, r.words[5][15:9], 1'h0};
    endproperty
    a_p5_tcmap: assert property (p_p5_tcmap) else $error("port 5 tc map wrong");

    property p_p2_pbcap;
        r.loaded |-> port_dw[2][RI_PBCAP] == {31'h0000_0000, r.words[2][15]};
    endproperty
    a_p2_pbcap: assert property (p_p2_pbcap) else $error("port 2 system allocated wrong");

    property p_p3_rest;
        port_dw[3][RI_SCLK] == 32'h0000_0000 && port_dw[3][RI_DSI] == 32'h0000_0000 &&
            port_dw[3][RI_LP_GROUP] == 32'h0000_0000 && port_dw[3][RI_PNUM] == 32'h0000_0000;
    endproperty
    a_p3_rest: assert property (p_p3_rest) else $error("port 3 field outside its map set");

    property p_pwr_no_map;
        port_dw[0][RI_TCMAP] == 32'h0000_0000 && port_dw[1][RI_PNUM] == 32'h0000_0000 &&
            port_dw[2][RI_DSI] == 32'h0000_0000;
    endproperty
    a_pwr_no_map: assert property (p_pwr_no_map) else $error("power port shows a map field");

    property p_full_no_pwr;
        port_dw[5][RI_PBDATA] == 32'h0000_0000 && port_dw[5][RI_PBCAP] == 32'h0000_0000 &&
            port_dw[4][RI_PBCAP] == 32'h0000_0000;
    endproperty
    a_full_no_pwr: assert property (p_full_no_pwr) else $error("map port shows a power field");

    property p_first_addr;
        r.mem_req && r.idx == 3'h0 |-> r.mem_addr == 8'h70;
    endproperty
    a_first_addr: assert property (p_first_addr) else $error("port 0 word fetched from wrong address");

    property p_p4_addr;
        r.mem_req && r.idx == 3'h4 |-> r.mem_addr == 8'h68;
    endproperty
    a_p4_addr: assert property (p_p4_addr) else $error("port 4 word fetched from wrong address");

    property p_p5_addr;
        r.mem_req && r.idx == 3'h5 |-> r.mem_addr == 8'h6A;
    endproperty
    a_p5_addr: assert property (p_p5_addr) else $error("port 5 word fetched from wrong address");

    property p_req_drop;
        r.mem_req && mem_rd_ack |=> !r.mem_req;
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("memory request held after its answer");

    property p_done_sticks;
        r.loaded |=> r.loaded;
    endproperty
    a_done_sticks: assert property (p_done_sticks) else $error("loaded flag dropped");

    property p_busy_state;
        r.busy == (r.st != ST_IDLE);
    endproperty
    a_busy_state: assert property (p_busy_state) else $error("busy flag out of step with loader");

    property p_bad_addr;
        setup && paddr[11:8] == 4'hF |=> r.pslverr && r.prdata == 32'h0000_0000;
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("unmapped access not refused");

    // host writes may never reach the loaded words
    property p_ro_window;
        access && pwrite && r.st != ST_COMMIT |=> $stable(r.words);
    endproperty
    a_ro_window: assert property (p_ro_window) else $error("host write changed loaded words");

    c_first_load: cover property (r.st == ST_COMMIT ##1 r.loaded);
    c_reload: cover property (reload_wr && r.loaded && !r.busy ##1 r.busy);
    c_bad_addr: cover property (access && r.pslverr);
    c_port_read: cover property (setup && !pwrite && paddr[11:8] == PORT_PAGE && r.loaded);

endmodule : ecl_loader

// File: hdl/ecl_pkg.sv
package ecl_pkg;

    localparam int NPORT = 6;
    localparam int NREG = 8;
    localparam int APB_AW = 12;
    localparam int MEM_AW = 8;
    localparam int WORD_W = 16;

    // memory word address for each port, index = port number
    localparam logic [NPORT-1:0][MEM_AW-1:0] WORD_ADDR = {8'h6A, 8'h68, 8'h66, 8'h74, 8'h72, 8'h70};

    // how a port's word is laid out
    localparam logic [1:0] K_PWR = 2'h0;
    localparam logic [1:0] K_MAP = 2'h1;
    localparam logic [1:0] K_FULL = 2'h2;
    localparam logic [NPORT-1:0][1:0] PORT_KIND = {K_FULL, K_FULL, K_MAP, K_PWR, K_PWR, K_PWR};

    // configuration offsets of the loaded fields
    localparam logic [11:0] CFG_DSI = 12'h040;
    localparam logic [11:0] CFG_SLOT = 12'h0C0;
    localparam logic [11:0] CFG_PNUM = 12'h0CC;
    localparam logic [11:0] CFG_SCLK = 12'h0D0;
    localparam logic [11:0] CFG_LP_GROUP = 12'h144;
    localparam logic [11:0] CFG_TCMAP = 12'h154;
    localparam logic [11:0] CFG_PBDATA = 12'h214;
    localparam logic [11:0] CFG_PBCAP = 12'h218;

    // register index of each offset inside a port window
    localparam int RI_DSI = 0;
    localparam int RI_SLOT = 1;
    localparam int RI_PNUM = 2;
    localparam int RI_SCLK = 3;
    localparam int RI_LP_GROUP = 4;
    localparam int RI_TCMAP = 5;
    localparam int RI_PBDATA = 6;
    localparam int RI_PBCAP = 7;

    // field positions: source bit in the word, destination bit in the dword
    localparam int SLOT_SRC = 0;
    localparam int SLOT_DST = 24;
    localparam int SCLK_SRC = 1;
    localparam int SCLK_DST = 28;
    localparam int DSI_SRC = 2;
    localparam int DSI_DST = 21;
    localparam int LP_GROUP_SRC = 3;
    localparam int LP_GROUP_DST = 4;
    localparam int PNUM_SRC = 4;
    localparam int PNUM_DST = 24;
    localparam int PNUM_W = 3;
    localparam int TCMAP_SRC = 9;
    localparam int TCMAP_DST = 1;
    localparam int TCMAP_W = 7;
    localparam int BPWR_SRC = 0;
    localparam int BPWR_DST = 0;
    localparam int BPWR_W = 10;
    localparam int PMST_SRC = 10;
    localparam int PMST_DST = 13;
    localparam int PMST_W = 2;
    localparam int SYSA_SRC = 15;
    localparam int SYSA_DST = 0;

    localparam logic [31:0] CFG_RST_VAL = 32'h0000_0000;

    // apb map
    localparam logic [APB_AW-1:0] CTRL_OFS = 12'h000;
    localparam logic [APB_AW-1:0] STAT_OFS = 12'h004;
    localparam logic [3:0] PORT_PAGE = 4'h1;
    localparam int CTRL_RELOAD = 0;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_STEP = 2'b11,
        ST_COMMIT = 2'b10
    } ecl_state_t;

    typedef struct packed {
        ecl_state_t st;
        logic [2:0] idx;
        logic started;
        logic busy;
        logic loaded;
        logic mem_req;
        logic [MEM_AW-1:0] mem_addr;
        logic [NPORT-1:0][WORD_W-1:0] stage;
        logic [NPORT-1:0][WORD_W-1:0] words;
        logic [31:0] prdata;
        logic pslverr;
    } ecl_regs_t;

endpackage : ecl_pkg

// File: hdl/ecl_word_map.sv
module ecl_word_map (
    input wire logic [1:0] kind,
    input wire logic loaded,
    input wire logic [ecl_pkg::WORD_W-1:0] word,
    output logic [ecl_pkg::NREG-1:0][31:0] dw
);
    import ecl_pkg::*;

    always_comb begin
        dw = {NREG{CFG_RST_VAL}};
        if (loaded && kind == K_FULL) begin
            dw[RI_SLOT][SLOT_DST] = word[SLOT_SRC];
            dw[RI_SCLK][SCLK_DST] = word[SCLK_SRC];
            dw[RI_DSI][DSI_DST] = word[DSI_SRC];
            dw[RI_LP_GROUP][LP_GROUP_DST] = word[LP_GROUP_SRC];
            dw[RI_PNUM][PNUM_DST +: PNUM_W] = word[PNUM_SRC +: PNUM_W];
        end
        if (loaded && kind != K_PWR) begin
            dw[RI_TCMAP][TCMAP_DST +: TCMAP_W] = word[TCMAP_SRC +: TCMAP_W];
        end
        if (loaded && kind == K_PWR) begin
            // base power sits in the same ten bits on both sides; data scale moves from word bits 11:10 to dword bits 14:13
            dw[RI_PBDATA][BPWR_DST +: BPWR_W] = word[BPWR_SRC +: BPWR_W];
            dw[RI_PBDATA][PMST_DST +: PMST_W] = word[PMST_SRC +: PMST_W];
            dw[RI_PBCAP][SYSA_DST] = word[SYSA_SRC];
        end
    end

endmodule : ecl_word_map

// File: verification/ecl_mem_model.sv
module ecl_mem_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic mem_rd_req,
    input wire logic [ecl_pkg::MEM_AW-1:0] mem_addr,
    input wire logic [3:0] dly,
    output logic mem_rd_ack,
    output logic [ecl_pkg::WORD_W-1:0] mem_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    import ecl_pkg::*;
    logic [WORD_W-1:0] mem [0:255];
    logic [3:0] cnt;
    logic hit;
    assign hit = mem_rd_req && !mem_rd_ack && cnt >= dly;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 4'h0;
            mem_rd_ack <= 1'b0;
            mem_rd_data <= 16'h0000;
        end else begin
            mem_rd_ack <= hit;
            cnt <= (mem_rd_req && !mem_rd_ack) ? cnt + 4'h1 : 4'h0;
            // data toggles outside the ack cycle so a stale word never looks valid
            mem_rd_data <= hit ? mem[mem_addr] : ~mem_rd_data;
        end
    end
endmodule : ecl_mem_model

// File: verification/tb_ecl_loader.sv
module tb_ecl_loader;
    timeunit 1ns;
    timeprecision 1ps;
    import ecl_pkg::*;
    logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic mem_rd_req, mem_rd_ack, load_busy, load_done;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [MEM_AW-1:0] mem_addr;
    logic [WORD_W-1:0] mem_rd_data;
    logic [3:0] dly;
    logic [WORD_W-1:0] w [6];
    logic [7:0] la [6] = '{8'h70, 8'h72, 8'h74, 8'h66, 8'h68, 8'h6A};
    logic [MEM_AW-1:0] seen [$];
    int n_fail, total_checks;

    ecl_loader ecl_loader_i (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .mem_rd_req, .mem_addr, .mem_rd_ack, .mem_rd_data, .load_busy, .load_done);
    ecl_mem_model ecl_mem_model_i (.sys_clk, .rst_n, .mem_rd_req, .mem_addr, .dly, .mem_rd_ack,
        .mem_rd_data);

    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (mem_rd_req === 1'b1 && mem_rd_ack === 1'b1) seen.push_back(mem_addr);

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk("pready", {31'h0, pready}, 32'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    function automatic logic [31:0] expv(int p, int i, logic [15:0] x);
        logic [31:0] v;
        v = 32'h0;
        if (p < 3 && i == 6) begin
            v[9:0] = x[9:0];
            v[14:13] = x[11:10];
        end
        if (p < 3 && i == 7) v[0] = x[15];
        if (p >= 3 && i == 5) v[7:1] = x[15:9];
        if (p >= 4) begin
            case (i)
                0: v[21] = x[2];
                1: v[24] = x[0];
                2: v[26:24] = x[6:4];
                3: v[28] = x[1];
                4: v[4] = x[3];
                default: v = v;
            endcase
        end
        return v;
    endfunction : expv

    task automatic set_pat(input logic [95:0] pat);
        for (int p = 0; p < 6; p++) begin
            w[p] = pat[p*16 +: 16];
            ecl_mem_model_i.mem[la[p]] = w[p];
        end
    endtask : set_pat

    task automatic wait_idle;
        int n;
        n = 0;
        while (load_busy !== 1'b0 && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
        chk("idle", {31'h0, load_busy}, 32'h0);
    endtask : wait_idle

    task automatic chk_all;
        logic [31:0] r;
        logic e;
        for (int p = 0; p < 6; p++) begin
            for (int i = 0; i < 8; i++) begin
                apb(1'b0, 12'h100 + 12'(p * 32 + i * 4), 32'h0, r, e);
                chk("cfg", r, expv(p, i, w[p]));
            end
        end
    endtask : chk_all

    task automatic t_boot;
        logic [31:0] r;
        logic e;
        repeat (2) @(posedge sys_clk);
        chk("busy", {31'h0, load_busy}, 32'h1);
        chk("done0", {31'h0, load_done}, 32'h0);
        apb(1'b0, 12'h184, 32'h0, r, e);
        chk("early", r, 32'h0);
        wait_idle;
        chk("done", {31'h0, load_done}, 32'h1);
        chk_all;
        apb(1'b0, 12'h004, 32'h0, r, e);
        chk("status", r, 32'h2);
        chk("count", 32'(seen.size()), 32'h6);
        for (int k = 0; k < 6 && k < seen.size(); k++) chk("addr", {24'h0, seen[k]}, {24'h0, la[k]});
    endtask : t_boot

    task automatic t_err;
        logic [31:0] r;
        logic e;
        apb(1'b0, 12'hFFC, 32'h0, r, e);
        chk("unmapped", {r[30:0], e}, 32'h1);
        // a host write into a loaded field must not stick
        apb(1'b1, 12'h118, 32'hFFFF_FFFF, r, e);
        apb(1'b0, 12'h118, 32'h0, r, e);
        chk("ro", r, expv(0, 6, w[0]));
    endtask : t_err

    task automatic t_reload(input logic [3:0] d, input logic [95:0] pat);
        logic [31:0] r;
        logic e;
        logic [15:0] old0;
        int n0;
        old0 = w[0];
        n0 = seen.size();
        dly <= d;
        set_pat(pat);
        apb(1'b1, 12'h000, 32'h1, r, e);
        repeat (2) @(posedge sys_clk);
        chk("rebusy", {31'h0, load_busy}, 32'h1);
        apb(1'b0, 12'h118, 32'h0, r, e);
        chk("hold", r, expv(0, 6, old0));
        // a start while busy must not add a pass
        apb(1'b1, 12'h000, 32'h1, r, e);
        wait_idle;
        chk("refetch", 32'(seen.size() - n0), 32'h6);
        chk_all;
    endtask : t_reload

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    initial begin
        #100000;
        n_fail++;
        close_out;
    end

    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        dly = 4'h3;
        n_fail = 0;
        total_checks = 0;
        set_pat(96'h5A2C_A5D3_FFFF_0F81_C3A5_2B7C);
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_boot;
        t_err;
        t_reload(4'h6, 96'h0000_FFFF_8001_0000_5F3E_FFFF);
        t_reload(4'h0, 96'hFFFF_1234_0000_E1C3_FFFF_96A8);
        close_out;
    end
endmodule : tb_ecl_loader
